// ==== src/cnt4_pkg.sv ====
// Purpose: Shared constants for the four-channel counter front end.
// Assumes: 100 MHz system clock; Avalon-MM word addressing.
// Notes:   Register indices are word addresses on the slave port.
package cnt4_pkg;

    ////////////////////////////////////////////////////////////////////
    // Timing.
    localparam int CLK_PERIOD_NS  = 10;
    // Fast inputs must pass a 100 kHz square wave: 5 us half period.
    localparam int FAST_STABLE_NS = 1000;
    localparam int FAST_CYC       =
        (FAST_STABLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Slow inputs are held to 1 kHz: 500 us half period.
    localparam int SLOW_STABLE_NS = 250000;
    localparam int SLOW_CYC       =
        (SLOW_STABLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    ////////////////////////////////////////////////////////////////////
    // Pin map of the sixteen digital inputs.
    localparam int          NUM_DI     = 16;
    localparam int          NUM_CH     = 4;
    localparam logic [15:0] FAST_MASK  = 16'h8EDB;
    localparam int          PIN_A [4]  = '{0, 3, 6, 9};
    localparam int          PIN_B [4]  = '{1, 4, 7, 10};
    localparam int          PIN_GATE3  = 11;
    localparam int          PIN_LATCH3 = 15;

    ////////////////////////////////////////////////////////////////////
    // Register indices.
    localparam logic [3:0] REG_CTRL0  = 4'h0;
    localparam logic [3:0] REG_LIMIT0 = 4'h4;
    localparam logic [3:0] REG_COUNT0 = 4'h8;
    localparam logic [3:0] REG_LATCH  = 4'hC;
    localparam logic [3:0] REG_STATUS = 4'hD;

    ////////////////////////////////////////////////////////////////////
    // Control register fields and reset value.
    localparam int         CTRL_W      = 10;
    localparam int         CB_RUN      = 0;
    localparam int         CB_ENC      = 1;
    localparam int         CB_EVAL     = 2;
    localparam int         CB_INV      = 4;
    localparam int         CB_MODE     = 5;
    localparam int         CB_HWGATE   = 7;
    localparam int         CB_ASSIGN   = 8;
    localparam int         CB_ALTOUT   = 9;
    localparam int         CB_CLEAR    = 10;
    localparam logic [9:0] CTRL_RESET  = 10'h000;

    // Edge evaluation and counting modes.
    localparam logic [1:0] EVAL_X1     = 2'h0;
    localparam logic [1:0] EVAL_X2     = 2'h1;
    localparam logic [1:0] EVAL_X4     = 2'h2;
    localparam logic [1:0] MODE_CONT   = 2'h0;
    localparam logic [1:0] MODE_ONCE   = 2'h1;
    localparam logic [1:0] MODE_PERIOD = 2'h2;

endpackage

// ==== src/cnt4_channel.sv ====
// Purpose: One counter channel: edge evaluation, direction, modes.
// Assumes: Inputs already synchronised and filtered on i_clk.
// Notes:   Simultaneous change of both encoder tracks counts as an A edge.
`timescale 1ns/10ps
module cnt4_channel
    import cnt4_pkg::*;
(
    // Clock, reset and enable.
    input  wire logic        i_clk,
    input  wire logic        i_rst_n,
    input  wire logic        i_ce,
    // Conditioned sensor levels.
    input  wire logic        i_a,
    input  wire logic        i_b,
    // Configuration.
    input  wire logic        i_gate,
    input  wire logic        i_clear,
    input  wire logic        i_encoder,
    input  wire logic [1:0]  i_eval,
    input  wire logic        i_invert,
    input  wire logic [1:0]  i_mode,
    input  wire logic [31:0] i_limit,
    // Channel state.
    output logic      [31:0] o_count,
    output logic             o_out,
    output logic             o_done
);

    logic        a_q_ff;
    logic        b_q_ff;
    logic [31:0] cnt_ff;
    logic        done_ff;
    logic        out_ff;
    logic        a_rise;
    logic        a_fall;
    logic        b_chg;
    logic        step;
    logic        up;
    logic [31:0] nxt_cnt;
    logic        cont_go;

    ////////////////////////////////////////////////////////////////////
    // Edge evaluation and direction.
    always_comb begin
        a_rise = i_a & ~a_q_ff;
        a_fall = ~i_a & a_q_ff;
        b_chg  = i_b ^ b_q_ff;
        if (i_eval == EVAL_X1) begin
            step = a_rise; // RULE_01
        end else if (i_eval == EVAL_X2) begin
            step = a_rise | a_fall;
        end else begin
            step = a_rise | a_fall | (i_encoder & b_chg & ~a_rise & ~a_fall);
        end
        // Track A leading B gives a_now xor b_before equal to one.
        if (i_encoder) begin
            up = (i_a ^ b_q_ff) ^ i_invert; // RULE_08 RULE_03
        end else begin
            up = i_b ^ i_invert; // RULE_09 RULE_03
        end
    end

    // Next count, with the period wrap folded in.
    always_comb begin
        nxt_cnt = up ? cnt_ff + 32'h1 : cnt_ff - 32'h1;
        if (i_mode == MODE_PERIOD) begin
            if (up && nxt_cnt == i_limit) begin
                nxt_cnt = 32'h0; // RULE_14
            end else if (!up && cnt_ff == 32'h0) begin
                nxt_cnt = i_limit - 32'h1;
            end
        end
    end

    // Previous samples of both tracks.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            a_q_ff <= 1'b0;
            b_q_ff <= 1'b0;
        end else if (i_ce) begin
            a_q_ff <= i_a;
            b_q_ff <= i_b;
        end
    end

    // Count and single-run stop; closing the gate rearms a single run.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt_ff  <= 32'h0;
            done_ff <= 1'b0;
        end else if (i_ce) begin
            if (i_clear) begin
                cnt_ff  <= 32'h0;
                done_ff <= 1'b0;
            end else if (!i_gate) begin
                done_ff <= 1'b0;
            end else if (step && !done_ff) begin
                cnt_ff <= nxt_cnt;
                if (i_mode == MODE_ONCE && nxt_cnt == i_limit) begin
                    done_ff <= 1'b1; // RULE_14
                end
            end
        end
    end

    // Output channel level: count at or past the limit.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            out_ff <= 1'b0;
        end else if (i_ce) begin
            out_ff <= (cnt_ff >= i_limit);
        end
    end

    assign o_count = cnt_ff;
    assign o_done  = done_ff;
    assign o_out   = out_ff;

    ////////////////////////////////////////////////////////////////////
    // Checks.
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    assign cont_go = i_ce & i_gate & ~i_clear & ~done_ff
                   & (i_mode == MODE_CONT);

    AST_X1_UP: assert property ( // RULE_01
        cont_go && i_encoder && i_eval == EVAL_X1 && a_rise
        && !b_q_ff && !i_invert |=> cnt_ff == $past(cnt_ff) + 32'h1)
        else $error("x1 rising A did not count up");
    AST_QUAD_X4: assert property ( // RULE_08
        cont_go && i_encoder && i_eval == EVAL_X4 && b_chg && !a_rise
        && !a_fall && (i_a ^ b_q_ff) && !i_invert
        |=> cnt_ff == $past(cnt_ff) + 32'h1)
        else $error("x4 track B edge did not count up");
    AST_PULSE_DIR: assert property ( // RULE_09
        cont_go && !i_encoder && a_rise && !i_b && !i_invert
        |=> cnt_ff == $past(cnt_ff) - 32'h1)
        else $error("low direction did not count down");
    AST_INVERT: assert property ( // RULE_03
        cont_go && !i_encoder && a_rise && !i_b && i_invert
        |=> cnt_ff == $past(cnt_ff) + 32'h1)
        else $error("inverted direction did not count up");
    AST_ONCE_STOP: assert property ( // RULE_14
        i_ce && i_gate && !i_clear && i_mode == MODE_ONCE && done_ff
        |=> $stable(cnt_ff) && done_ff)
        else $error("single run kept counting after its limit");

endmodule // cnt4_channel

// ==== src/cnt4_front.sv ====
// Purpose: Input front end, register file and four counter channels.
// Assumes: i_di are raw pins; i_pwm comes from logic on i_clk.
// Notes:   Bus stalls while i_ce is low, since all state is frozen.
`timescale 1ns/10ps

// Function
// RULE_01 - Pulse input counts plain pulses or track A, one two or four fold.
// RULE_02 - Second input is direction level or track B by sensor type.
// RULE_03 - A per-channel bit inverts the direction signal.
// RULE_04 - When enabled, a rising gate pin edge opens channel 3 gate.
// RULE_05 - A rising latch pin edge stores channel 3 count for reading.
// RULE_06 - Each channel's input assignment is chosen by configuration.
// RULE_07 - Counting inputs pass 100 kHz; other inputs are limited to 1 kHz.
// RULE_08 - Quadrature tracks give both count and direction from phase.
// RULE_09 - Pulse trains with a direction level count up or down.
// RULE_10 - Channel 0 uses bits 0 and 1; bit 1 also feeds frequency 0.
// RULE_11 - Channel 1 uses bits 3 and 4, channel 2 bits 6 and 7.
// RULE_12 - Channel 3 uses bits 9, 10, gate 11 and latch 15.
// RULE_13 - Channel n drives output bit n; bits 0 and 1 may carry PWM.
// RULE_14 - Four channels with single, continuous and periodic modes.
// RULE_15 - Gate and latch edges seen as synchronised 0 then 1 samples.
module cnt4_front
    import cnt4_pkg::*;
#(
    parameter int SLOW_CYC_P = SLOW_CYC
)
(
    // Clock, reset and enable.
    input  wire logic        i_clk,
    input  wire logic        i_rst_n,
    input  wire logic        i_ce,
    // Digital input pins and pulse-width sources.
    input  wire logic [15:0] i_di,
    input  wire logic [1:0]  i_pwm,
    // Avalon-MM slave.
    input  wire logic [3:0]  i_avs_address,
    input  wire logic        i_avs_read,
    input  wire logic        i_avs_write,
    input  wire logic [31:0] i_avs_writedata,
    input  wire logic [3:0]  i_avs_byteenable,
    output logic      [31:0] o_avs_readdata,
    output logic             o_avs_waitrequest,
    // Output channels and frequency inputs.
    output logic      [3:0]  o_do,
    output logic      [3:0]  o_freq_in
);

    logic [15:0]       sy1_ff;
    logic [15:0]       sy2_ff;
    logic [15:0]       flt;
    logic              gate_q_ff;
    logic              latch_q_ff;
    logic              gate_rise;
    logic              latch_rise;
    logic [CTRL_W-1:0] ctrl_ff [NUM_CH];
    logic [31:0]       limit_ff [NUM_CH];
    logic [3:0]        clr_ff;
    logic              hw_open_ff;
    logic [31:0]       latch_ff;
    logic              latch_new_ff;
    logic              ack_ff;
    logic [31:0]       rdata_ff;
    logic [31:0]       rd_mux;
    logic [31:0]       wmask;
    logic              wr_go;
    logic              rd_go;
    logic [31:0]       cnt [NUM_CH];
    logic [3:0]        outs;
    logic [3:0]        done;
    logic [3:0]        gate;
    logic [3:0]        do_ff;

    ////////////////////////////////////////////////////////////////////
    // Pin synchronisers; only the second stage is read further on.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sy1_ff <= 16'h0000;
            sy2_ff <= 16'h0000;
        end else if (i_ce) begin
            sy1_ff <= i_di;
            sy2_ff <= sy1_ff;
        end
    end

    // Stability filters: fast pins settle in FAST_CYC, others in the
    // slow count, which is what holds plain inputs to 1 kHz.
    for (genvar g = 0; g < NUM_DI; g++) begin : g_flt
        localparam logic [15:0] LIM = FAST_MASK[g] ? 16'(FAST_CYC)
                                                    : 16'(SLOW_CYC_P);
        logic [15:0] st_cnt_ff;
        logic        lvl_ff;
        always_ff @(posedge i_clk or negedge i_rst_n) begin
            if (!i_rst_n) begin
                st_cnt_ff <= 16'h0000;
                lvl_ff    <= 1'b0;
            end else if (i_ce) begin
                if (sy2_ff[g] == lvl_ff) begin
                    st_cnt_ff <= 16'h0000;
                end else if (st_cnt_ff >= LIM - 16'h0001) begin
                    lvl_ff    <= sy2_ff[g]; // RULE_07
                    st_cnt_ff <= 16'h0000;
                end else begin
                    st_cnt_ff <= st_cnt_ff + 16'h0001;
                end
            end
        end
        assign flt[g] = lvl_ff;
    end

    ////////////////////////////////////////////////////////////////////
    // Gate and latch edge detection on the filtered levels.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            gate_q_ff  <= 1'b0;
            latch_q_ff <= 1'b0;
        end else if (i_ce) begin
            gate_q_ff  <= flt[PIN_GATE3];
            latch_q_ff <= flt[PIN_LATCH3];
        end
    end

    assign gate_rise  = flt[PIN_GATE3] & ~gate_q_ff; // RULE_15
    assign latch_rise = flt[PIN_LATCH3] & ~latch_q_ff; // RULE_15

    ////////////////////////////////////////////////////////////////////
    // Bus handshake: one wait cycle, then the access completes.
    assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack_ff;
    assign wr_go = i_avs_write & ack_ff;
    assign rd_go = i_avs_read & ack_ff;
    assign wmask = {{8{i_avs_byteenable[3]}}, {8{i_avs_byteenable[2]}},
                    {8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ack_ff <= 1'b0;
        end else if (i_ce) begin
            ack_ff <= (i_avs_read | i_avs_write) & ~ack_ff;
        end
    end

    // Read mux; unmapped indices read as zero.
    always_comb begin
        rd_mux = 32'h0000_0000;
        for (int n = 0; n < NUM_CH; n++) begin
            if (i_avs_address == REG_CTRL0 + 4'(n)) begin
                rd_mux = {22'h000000, ctrl_ff[n]};
            end
            if (i_avs_address == REG_LIMIT0 + 4'(n)) begin
                rd_mux = limit_ff[n];
            end
            if (i_avs_address == REG_COUNT0 + 4'(n)) begin
                rd_mux = cnt[n];
            end
        end
        if (i_avs_address == REG_LATCH) begin
            rd_mux = latch_ff;
        end
        if (i_avs_address == REG_STATUS) begin
            rd_mux = {flt, 6'h00, latch_new_ff, hw_open_ff, done, outs};
        end
    end

    // Read data is caught in the wait cycle and stands at the ack edge.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rdata_ff <= 32'h0000_0000;
        end else if (i_ce && i_avs_read && !ack_ff) begin
            rdata_ff <= rd_mux;
        end
    end

    assign o_avs_readdata = rdata_ff;

    ////////////////////////////////////////////////////////////////////
    // Control and limit registers; the clear bit is a one-cycle pulse.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            for (int n = 0; n < NUM_CH; n++) begin
                ctrl_ff[n]  <= CTRL_RESET;
                limit_ff[n] <= 32'h0000_0000;
            end
            clr_ff <= 4'h0;
        end else if (i_ce) begin
            for (int n = 0; n < NUM_CH; n++) begin
                clr_ff[n] <= 1'b0;
                if (wr_go && i_avs_address == REG_CTRL0 + 4'(n)) begin
                    ctrl_ff[n] <= (ctrl_ff[n] & ~wmask[CTRL_W-1:0])
                        | (i_avs_writedata[CTRL_W-1:0] & wmask[CTRL_W-1:0]);
                    clr_ff[n]  <= i_avs_writedata[CB_CLEAR]
                                & i_avs_byteenable[1];
                end
                if (wr_go && i_avs_address == REG_LIMIT0 + 4'(n)) begin
                    limit_ff[n] <= (limit_ff[n] & ~wmask)
                                 | (i_avs_writedata & wmask);
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Hardware count gate of channel 3: opened by a gate edge while
    // running, closed when software drops the run bit.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            hw_open_ff <= 1'b0;
        end else if (i_ce) begin
            if (gate_rise && ctrl_ff[3][CB_HWGATE] && ctrl_ff[3][CB_RUN]
                && ctrl_ff[3][CB_ASSIGN]) begin
                hw_open_ff <= 1'b1; // RULE_04
            end else if (!ctrl_ff[3][CB_RUN]) begin
                hw_open_ff <= 1'b0;
            end
        end
    end

    // Capture register of channel 3; a new capture beats the read clear.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            latch_ff     <= 32'h0000_0000;
            latch_new_ff <= 1'b0;
        end else if (i_ce) begin
            if (latch_rise && ctrl_ff[3][CB_ASSIGN]) begin
                latch_ff     <= cnt[3]; // RULE_05
                latch_new_ff <= 1'b1;
            end else if (rd_go && i_avs_address == REG_LATCH) begin
                latch_new_ff <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Channels; an unassigned channel has its gate held shut.
    for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
        logic hw_ok;
        if (c == 3) begin : g_hw
            assign hw_ok = ~ctrl_ff[c][CB_HWGATE] | hw_open_ff;
        end else begin : g_sw
            assign hw_ok = 1'b1;
        end
        assign gate[c] = ctrl_ff[c][CB_RUN] & ctrl_ff[c][CB_ASSIGN]
                       & hw_ok; // RULE_06

        cnt4_channel u_ch (
            .i_clk     (i_clk),
            .i_rst_n   (i_rst_n),
            .i_ce      (i_ce),
            .i_a       (flt[PIN_A[c]]), // RULE_10 RULE_11 RULE_12
            .i_b       (flt[PIN_B[c]]), // RULE_02
            .i_gate    (gate[c]),
            .i_clear   (clr_ff[c]),
            .i_encoder (ctrl_ff[c][CB_ENC]),
            .i_eval    (ctrl_ff[c][CB_EVAL+1:CB_EVAL]),
            .i_invert  (ctrl_ff[c][CB_INV]),
            .i_mode    (ctrl_ff[c][CB_MODE+1:CB_MODE]),
            .i_limit   (limit_ff[c]),
            .o_count   (cnt[c]),
            .o_out     (outs[c]),
            .o_done    (done[c])
        );
    end

    ////////////////////////////////////////////////////////////////////
    // Output bits: channel n on bit n, or PWM on bits 0 and 1.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            do_ff <= 4'h0;
        end else if (i_ce) begin
            for (int n = 0; n < NUM_CH; n++) begin
                if (!ctrl_ff[n][CB_ALTOUT]) begin
                    do_ff[n] <= outs[n]; // RULE_13
                end else if (n < 2) begin
                    do_ff[n] <= i_pwm[n];
                end else begin
                    do_ff[n] <= 1'b0;
                end
            end
        end
    end

    assign o_do      = do_ff;
    assign o_freq_in = {flt[PIN_B[3]], flt[PIN_B[2]], flt[PIN_B[1]],
                        flt[PIN_B[0]]}; // RULE_10

    ////////////////////////////////////////////////////////////////////
    // Checks.
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    sequence latch_edge_s;
        i_ce && latch_rise && ctrl_ff[3][CB_ASSIGN];
    endsequence

    AST_GATE_OPEN: assert property ( // RULE_04
        i_ce && gate_rise && ctrl_ff[3][CB_HWGATE] && ctrl_ff[3][CB_RUN]
        && ctrl_ff[3][CB_ASSIGN] |=> hw_open_ff)
        else $error("gate edge did not open the hardware gate");
    AST_LATCH: assert property ( // RULE_05
        latch_edge_s |=> latch_ff == $past(cnt[3]) && latch_new_ff)
        else $error("latch edge did not capture the count");
    AST_EDGE_SEEN: assert property ( // RULE_15
        i_ce && !flt[PIN_LATCH3] ##1 i_ce && flt[PIN_LATCH3]
        |-> latch_rise)
        else $error("latch level 0 then 1 was not taken as an edge");
    AST_DO_MAP: assert property ( // RULE_13
        i_ce && !ctrl_ff[2][CB_ALTOUT] |=> o_do[2] == $past(outs[2]))
        else $error("output bit 2 does not follow channel 2");
    AST_FILTER: assert property ( // RULE_07
        i_ce && $changed(flt[0]) |-> flt[0] == $past(sy2_ff[0]))
        else $error("filtered input moved against its pin");
    AST_ASSIGN: assert property ( // RULE_06
        i_ce && !ctrl_ff[1][CB_ASSIGN] && !clr_ff[1]
        |=> cnt[1] == $past(cnt[1]))
        else $error("unassigned channel counted");

endmodule // cnt4_front

// ==== testbench/enc_model.sv ====
// Purpose: Encoder and pulse sensor model for one pin pair.
// Assumes: Steps are slower than the fast input filter.
// Notes:   Pulse mode toggles A each step; B holds the direction.
`timescale 1ns/10ps
module enc_model #(
    parameter int HALF = 150
)
(
    // Clock and request.
    input  wire logic       i_clk,
    input  wire logic       i_start,
    input  wire logic [7:0] i_n,
    input  wire logic       i_up,
    input  wire logic       i_quad,
    // Sensor lines and status.
    output logic            o_a,
    output logic            o_b,
    output logic            o_busy
);
    logic [1:0] ph;

    // Lines start low, as a sensor at rest would leave them.
    initial begin
        {o_a, o_b, o_busy, ph} = 5'h00;
    end

    // One step per HALF cycles; quicker steps would only exercise
    // the filter, not the counter.
    always begin
        @(posedge i_clk);
        if (i_start === 1'b1) begin
            o_busy <= 1'b1;
            if (!i_quad) o_b <= i_up;
            repeat (i_n) begin
                repeat (HALF) @(posedge i_clk);
                if (i_quad) begin
                    ph = i_up ? ph + 2'h1 : ph - 2'h1;
                    o_a <= ph[1] ^ ph[0];
                    o_b <= ph[1];
                end else begin
                    o_a <= ~o_a;
                end
            end
            o_busy <= 1'b0;
        end
    end
endmodule // enc_model

// ==== testbench/tb.sv ====
// Purpose: Self-checking bench for the four-channel counter front.
// Assumes: Slow filter shortened to 20 cycles.
// Notes:   One sensor model is steered onto the chosen channel pins.
`timescale 1ns/10ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin fails++; \
$display("CHECK FAILED t=%0t got %h exp %h", $time, (g), (e)); end end
module tb
    import cnt4_pkg::*;
;
    logic        i_clk, i_rst_n, start, up, quad, a, b, busy, rd, wr, wreq;
    logic [7:0]  nstep;
    logic [15:0] base, di;
    logic [3:0]  adr, o_do, o_freq_in;
    logic [31:0] wd, rdat, q;
    int          sel, fails, check_count;

    enc_model enc_model_i (.i_clk(i_clk), .i_start(start), .i_n(nstep),
        .i_up(up), .i_quad(quad), .o_a(a), .o_b(b), .o_busy(busy));
    cnt4_front #(.SLOW_CYC_P(20)) cnt4_front_i (.i_clk(i_clk),
        .i_rst_n(i_rst_n), .i_ce(1'b1), .i_di(di), .i_pwm(2'b01),
        .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr),
        .i_avs_writedata(wd), .i_avs_byteenable(4'hF),
        .o_avs_readdata(rdat), .o_avs_waitrequest(wreq),
        .o_do(o_do), .o_freq_in(o_freq_in));

    // Sensor lines land on the pins of the selected channel.
    always_comb begin
        di = base;
        di[PIN_A[sel]] = a;
        di[PIN_B[sel]] = b;
    end

    // The clock runs free at 100 MHz.
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end

    ////////////////////////////////////////////////////////////////////
    // One bus access; the request stands until waitrequest is low.
    task automatic bus(input logic w, input logic [3:0] ad,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge i_clk);
        adr <= ad;
        wr  <= w;
        rd  <= !w;
        wd  <= d;
        @(posedge i_clk);
        while (wreq !== 1'b0 && n < 50) begin
            @(posedge i_clk);
            n++;
        end
        // A bus that never answers counts as a mismatch.
        if (wreq !== 1'b0) fails++;
        q = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask

    task automatic rchk(input logic [3:0] ad, input logic [31:0] e);
        bus(1'b0, ad, 32'h0);
        `CHK(q, e)
    endtask

    // Let the model run n steps, then allow for filter latency.
    task automatic mv(input int s, input logic [7:0] n, input logic u,
                      input logic qd);
        int k;
        k = 0;
        @(posedge i_clk);
        sel   <= s;
        up    <= u;
        quad  <= qd;
        nstep <= n;
        start <= 1'b1;
        @(posedge i_clk);
        start <= 1'b0;
        @(posedge i_clk);
        while (busy !== 1'b0 && k < 5000) begin
            @(posedge i_clk);
            k++;
        end
        if (busy !== 1'b0) fails++;
        repeat (150) @(posedge i_clk);
    endtask

    ////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        rchk(REG_CTRL0, 32'h0);
        // Limits reset to zero, so every output bit starts high.
        rchk(REG_STATUS, 32'h0000000F);
        bus(1'b1, 4'hE, 32'hFFFFFFFF);
        rchk(4'hE, 32'h0);
        $display("test regs done");
    endtask

    task automatic t_quad();
        for (int e = 0; e < 3; e++) begin
            bus(1'b1, REG_CTRL0, 32'h00000503 | (e << 2));
            mv(0, 8'h08, 1'b1, 1'b1);
            rchk(REG_COUNT0, 32'h2 << e);
        end
        mv(0, 8'h04, 1'b0, 1'b1);
        rchk(REG_COUNT0, 32'h4);
        $display("test quad done");
    endtask

    task automatic t_pulse();
        bus(1'b1, 4'h1, 32'h00000501);
        mv(1, 8'h08, 1'b1, 1'b0);
        rchk(4'h9, 32'h4);
        `CHK(o_freq_in[1], 1'b1)
        mv(1, 8'h04, 1'b0, 1'b0);
        rchk(4'h9, 32'h2);
        bus(1'b1, 4'h1, 32'h00000111);
        mv(1, 8'h04, 1'b1, 1'b0);
        rchk(4'h9, 32'h0);
        $display("test pulse done");
    endtask

    task automatic t_modes();
        bus(1'b1, 4'h6, 32'h3);
        bus(1'b1, 4'h2, 32'h00000521);
        mv(2, 8'h0C, 1'b1, 1'b0);
        rchk(4'hA, 32'h3);
        `CHK(o_do[2], 1'b1)
        bus(1'b0, REG_STATUS, 32'h0);
        `CHK(q[6], 1'b1)
        bus(1'b1, 4'h2, 32'h00000541);
        mv(2, 8'h0A, 1'b1, 1'b0);
        rchk(4'hA, 32'h2);
        `CHK(o_do[2], 1'b0)
        // Channel 1 alone would drive a high bit; its PWM source is low.
        bus(1'b1, REG_CTRL0, 32'h00000300);
        bus(1'b1, 4'h1, 32'h00000300);
        repeat (5) @(posedge i_clk);
        `CHK(o_do[1:0], 2'b01)
        $display("test modes done");
    endtask

    task automatic t_gate();
        bus(1'b1, 4'h3, 32'h00000581);
        mv(3, 8'h04, 1'b1, 1'b0);
        rchk(4'hB, 32'h0);
        base[11] <= 1'b1;
        repeat (150) @(posedge i_clk);
        mv(3, 8'h06, 1'b1, 1'b0);
        rchk(4'hB, 32'h3);
        base[15] <= 1'b1;
        repeat (150) @(posedge i_clk);
        bus(1'b0, REG_STATUS, 32'h0);
        `CHK(q[9:8], 2'b11)
        mv(3, 8'h04, 1'b1, 1'b0);
        rchk(REG_LATCH, 32'h3);
        bus(1'b0, REG_STATUS, 32'h0);
        `CHK(q[9], 1'b0)
        $display("test gate done");
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // Reset, then the scenarios in turn.
    initial begin
        {i_rst_n, start, up, quad, rd, wr} = 6'h00;
        {nstep, base, adr, wd} = 60'h0;
        {sel, fails, check_count} = 96'h0;
        repeat (16) @(posedge i_clk);
        i_rst_n <= 1'b1;
        t_regs();
        t_quad();
        t_pulse();
        t_modes();
        t_gate();
        finish_test();
    end

    // A hang counts as a mismatch.
    initial begin
        repeat (100000) @(posedge i_clk);
        fails++;
        finish_test();
    end
endmodule // tb
